// ===== core/esam_monitor.sv
// Errored-second and unavailable-second monitor with the excess error alarm.
module esam_monitor
	import esam_pkg::*;
#(
	parameter int unsigned P_TICK_CYCLES = TICK_CYCLES_DFLT
) (
	// Clock and reset.
	input  wire logic             i_clk,
	input  wire logic             i_rst_b,
	// Line events and management commands.
	input  wire esam_line_s       i_line,
	input  wire esam_cmd_s        i_cmd,
	// Alarm enables and alarm outputs.
	output logic                  o_ais_alarm_enable,
	output logic                  o_yellow_alarm_enable,
	output logic                  o_ais_alarm,
	output logic                  o_yellow_alarm,
	output logic                  o_excess_error_alarm,
	// Status for management.
	output logic                  o_unavailable,
	output logic [CNT_W-1:0]      o_errsec_count,
	output logic [CNT_W-1:0]      o_unavail_count,
	output logic [CNT_W-1:0]      o_errsec_threshold,
	output logic [CNT_W-1:0]      o_unavail_threshold,
	output logic                  o_second_tick
);

	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(P_TICK_CYCLES - 1);

	// Configuration state and its next values.
	logic                 ais_en;
	logic                 yel_en;
	logic [CNT_W-1:0]     es_thr;
	logic [CNT_W-1:0]     uas_thr;
	logic                 next_ais_en;
	logic                 next_yel_en;
	logic [CNT_W-1:0]     next_es_thr;
	logic [CNT_W-1:0]     next_uas_thr;

	// Second accounting state.
	logic [TICK_W-1:0]    tick_cnt;     // Divider toward the one-second tick.
	logic                 tick;         // One-cycle pulse ending each second.
	logic                 los_d;        // Previous loss-of-signal level.
	logic                 oof_d;        // Previous out-of-frame level.
	logic [EVT_W-1:0]     evt_cnt;      // Events so far in this second, saturating.
	logic                 unavail;      // Unavailable state.
	logic [RUN_W-1:0]     ses_run;      // Consecutive severe seconds.
	logic [RUN_W-1:0]     clr_run;      // Consecutive non-severe seconds.
	logic [TICK_W-1:0]    next_tick_cnt;
	logic                 next_tick;
	logic [EVT_W-1:0]     next_evt_cnt;
	logic                 next_unavail;
	logic [RUN_W-1:0]     next_ses_run;
	logic [RUN_W-1:0]     next_clr_run;
	logic [1:0]           cur_evts;     // Events arriving this cycle.
	logic [EVT_W-1:0]     sec_evts;     // Total for the closing second.
	logic                 sec_ses;      // Closing second is severely errored.
	logic                 new_es;       // Closing second is an errored second.
	logic                 new_uas;      // Closing second is an unavailable second.

	// Sliding window: one class pair per second, in a ring.
	logic [1:0]           hist [WIN_SECS];
	logic [CNT_W-1:0]     ptr;
	logic [CNT_W-1:0]     es_cnt;
	logic [CNT_W-1:0]     uas_cnt;
	logic [CNT_W-1:0]     next_ptr;
	logic [CNT_W-1:0]     next_es_cnt;
	logic [CNT_W-1:0]     next_uas_cnt;
	logic [1:0]           old_cls;
	logic                 next_alarm;

	// Returns true when a count has reached a nonzero threshold.
	// A zero threshold switches its criterion off rather than alarming at once.
	function automatic logic thr_hit(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] thr);
		thr_hit = (thr != '0) && (cnt >= thr);
	endfunction

	// Commands update the enables and thresholds. A set and clear in the same
	// cycle leaves the enable set, so an alarm is never silently lost.
	always_comb begin
		next_ais_en  = ais_en;
		next_yel_en  = yel_en;
		next_es_thr  = es_thr;
		next_uas_thr = uas_thr;
		if (i_cmd.ais_alarm_off_cmd) begin
			next_ais_en = 1'b0;
		end
		if (i_cmd.ais_alarm_on_cmd) begin
			next_ais_en = 1'b1;
		end
		if (i_cmd.yellow_alarm_off_cmd) begin
			next_yel_en = 1'b0;
		end
		if (i_cmd.yellow_alarm_on_cmd) begin
			next_yel_en = 1'b1;
		end
		// Values above the window length are refused, the old threshold stays.
		if (i_cmd.errsec_threshold_cmd && (i_cmd.value <= THR_MAX)) begin
			next_es_thr = i_cmd.value;
		end
		if (i_cmd.unavail_threshold_cmd && (i_cmd.value <= THR_MAX)) begin
			next_uas_thr = i_cmd.value;
		end
	end

	// Configuration registers with their reset defaults.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			ais_en  <= 1'b1;
			yel_en  <= 1'b1;
			es_thr  <= ES_THR_RST;
			uas_thr <= UAS_THR_RST;
		end else begin
			ais_en  <= next_ais_en;
			yel_en  <= next_yel_en;
			es_thr  <= next_es_thr;
			uas_thr <= next_uas_thr;
		end
	end

	// Event counting, the tick divider and second classification. Events that
	// land in the tick cycle belong to the closing second, so none are dropped.
	always_comb begin
		cur_evts = {1'b0, i_line.los & ~los_d} + {1'b0, i_line.oof & ~oof_d}
			+ {1'b0, i_line.cv};
		if (({1'b0, evt_cnt} + {5'h00, cur_evts}) > {1'b0, EVT_MAX}) begin
			sec_evts = EVT_MAX;
		end else begin
			sec_evts = evt_cnt + {4'h0, cur_evts};
		end
		sec_ses       = (sec_evts >= SES_EVTS);
		next_tick     = (tick_cnt == TICK_LAST);
		next_tick_cnt = next_tick ? '0 : tick_cnt + 1'b1;
		next_evt_cnt  = tick ? '0 : sec_evts;
		next_unavail  = unavail;
		next_ses_run  = ses_run;
		next_clr_run  = clr_run;
		if (tick) begin
			next_ses_run = sec_ses ? ((ses_run == UAS_RUN) ? ses_run : ses_run + 1'b1) : '0;
			next_clr_run = sec_ses ? '0 : ((clr_run == UAS_RUN) ? clr_run : clr_run + 1'b1);
			if (!unavail && (next_ses_run == UAS_RUN)) begin
				next_unavail = 1'b1;
			end else if (unavail && (next_clr_run == UAS_RUN)) begin
				next_unavail = 1'b0;
			end
		end
		// The second that completes the severe run already counts as unavailable.
		new_uas = tick && next_unavail;
		new_es  = tick && !next_unavail && (sec_evts != '0);
	end

	// Second accounting registers.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			tick_cnt <= '0;
			tick     <= 1'b0;
			los_d    <= 1'b0;
			oof_d    <= 1'b0;
			evt_cnt  <= '0;
			unavail  <= 1'b0;
			ses_run  <= '0;
			clr_run  <= '0;
		end else begin
			tick_cnt <= next_tick_cnt;
			tick     <= next_tick;
			los_d    <= i_line.los;
			oof_d    <= i_line.oof;
			evt_cnt  <= next_evt_cnt;
			unavail  <= next_unavail;
			ses_run  <= next_ses_run;
			clr_run  <= next_clr_run;
		end
	end

	// Window update: the newest class enters, the class of the second that
	// falls out of the window leaves. The ring is never cleared, not even by the count
	// reset; stale entries are masked by a valid bit set at the first pointer wrap.
	logic full;        // The ring has wrapped once since reset.
	logic next_full;
	always_comb begin
		// Before the first wrap the ring holds nothing that may leave the window.
		old_cls      = full ? hist[ptr] : 2'h0;
		next_ptr     = ptr;
		next_full    = full;
		next_es_cnt  = es_cnt;
		next_uas_cnt = uas_cnt;
		if (tick) begin
			next_ptr     = (ptr == PTR_LAST) ? '0 : ptr + 1'b1;
			next_full    = full || (ptr == PTR_LAST);
			next_es_cnt  = es_cnt + {9'h000, new_es} - {9'h000, old_cls[0]};
			next_uas_cnt = uas_cnt + {9'h000, new_uas} - {9'h000, old_cls[1]};
		end
		// Either criterion raises the one shared alarm; zero disables it.
		next_alarm = thr_hit(es_cnt, es_thr) || thr_hit(uas_cnt, uas_thr);
	end

	// Window registers and the ring memory.
	always_ff @(posedge i_clk) begin
		if (tick) begin
			hist[ptr] <= {new_uas, new_es};
		end
		if (!i_rst_b) begin
			ptr     <= '0;
			full    <= 1'b0;
			es_cnt  <= '0;
			uas_cnt <= '0;
		end else begin
			ptr     <= next_ptr;
			full    <= next_full;
			es_cnt  <= next_es_cnt;
			uas_cnt <= next_uas_cnt;
		end
	end

	// Registered outputs. Detection itself is untouched by the enables; only
	// the reported alarm is gated.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_ais_alarm          <= 1'b0;
			o_yellow_alarm       <= 1'b0;
			o_excess_error_alarm <= 1'b0;
		end else begin
			o_ais_alarm          <= ais_en & i_line.ais;
			o_yellow_alarm       <= yel_en & i_line.yel;
			o_excess_error_alarm <= next_alarm;
		end
	end

	// Status outputs taken straight from the state flip-flops.
	assign o_ais_alarm_enable    = ais_en;
	assign o_yellow_alarm_enable = yel_en;
	assign o_unavailable         = unavail;
	assign o_errsec_count        = es_cnt;
	assign o_unavail_count       = uas_cnt;
	assign o_errsec_threshold    = es_thr;
	assign o_unavail_threshold   = uas_thr;
	assign o_second_tick         = tick;

	// Checks next to the logic they guard.
	// They rest while reset is low, so reset values never count as a failure.
	chk_ais_reset_on: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!$past(i_rst_b) |-> ais_en && yel_en)
		else $error("enables not set after reset");
	chk_ais_on_cmd: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_cmd.ais_alarm_on_cmd |=> ais_en ##1 (ais_en || $past(i_cmd.ais_alarm_off_cmd)))
		else $error("AIS enable command lost");
	chk_ais_off_cmd: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_cmd.ais_alarm_off_cmd && !i_cmd.ais_alarm_on_cmd |=> !ais_en)
		else $error("AIS disable command lost");
	chk_yel_cmds: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_cmd.yellow_alarm_off_cmd && !i_cmd.yellow_alarm_on_cmd |=> !yel_en ##1 (!o_yellow_alarm || yel_en))
		else $error("yellow disable not honoured");
	chk_thr_reset: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!$past(i_rst_b) |-> (es_thr == ES_THR_RST) && (uas_thr == UAS_THR_RST))
		else $error("threshold reset values wrong");
	chk_thr_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_cmd.errsec_threshold_cmd && (i_cmd.value <= THR_MAX) |=> es_thr == $past(i_cmd.value))
		else $error("errored-second threshold not written");
	chk_uthr_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_cmd.unavail_threshold_cmd && (i_cmd.value > THR_MAX) |=> $stable(uas_thr))
		else $error("out-of-range threshold accepted");
	chk_event_count: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!tick && i_line.cv && (evt_cnt < SES_EVTS) |=> evt_cnt > $past(evt_cnt))
		else $error("code violation not counted");
	chk_errsec_class: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		tick && (sec_evts != '0) && !next_unavail |=> es_cnt != $past(es_cnt) || $past(old_cls[0]))
		else $error("errored second not counted");
	chk_uas_entry: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		tick && !unavail && sec_ses && (ses_run == UAS_RUN - 4'h1) |=> unavail)
		else $error("unavailable state not entered");
	chk_window_slide: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!tick |=> $stable(es_cnt) && $stable(uas_cnt))
		else $error("window count moved without a tick");
	chk_es_alarm: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(es_thr != '0) && (es_cnt >= es_thr) |=> o_excess_error_alarm)
		else $error("errored-second alarm missing");
	chk_uas_alarm: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(uas_thr != '0) && (uas_cnt >= uas_thr) |=> o_excess_error_alarm)
		else $error("unavailable-second alarm missing");
	chk_zero_thr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$past(es_thr == '0) && $past(uas_thr == '0) |-> !o_excess_error_alarm)
		else $error("alarm with both thresholds zero");

	// The AIS alarm follows its enable one cycle later; then second-class, count and zero-threshold checks.
	chk_ais_report: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_rst_b && ais_en && i_line.ais |=> o_ais_alarm)
		else $error("enabled AIS alarm not reported");
	chk_ais_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!ais_en |=> !o_ais_alarm)
		else $error("disabled AIS alarm reported");
	chk_ses_class: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		tick && (sec_evts < SES_EVTS) |=> ses_run == '0)
		else $error("second below the severe count kept the run");
	chk_uas_count: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		tick && next_unavail |=> uas_cnt != $past(uas_cnt) || $past(old_cls[1]))
		else $error("unavailable second not counted");
	chk_es_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$past(es_thr == '0) && $past(uas_thr == '0 || uas_cnt < uas_thr)
		|-> !o_excess_error_alarm)
		else $error("alarm on errored seconds with a zero threshold");
	chk_uas_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$past(uas_thr == '0) && $past(es_thr == '0 || es_cnt < es_thr)
		|-> !o_excess_error_alarm)
		else $error("alarm on unavailable seconds with a zero threshold");

endmodule

// ===== core/esam_pkg.sv
// Constants, carriers and the rule summary for the errored-second alarm monitor.
//Contract
//- AIS alarm reporting enabled after reset.
//- AIS enable command sets AIS flag.
//- AIS disable command clears AIS flag.
//- Errored second: available, one event or more.
//- LOS entry, OOF entry, violation are events.
//- Errored-second threshold programmable 0 to 900.
//- Zero errored-second threshold never alarms.
//- Threshold 900 alarms only on all-errored window.
//- Errored-second threshold resets to 65.
//- Errored count reaching threshold raises alarm.
//- Severely errored means 44 events or more.
//- Ten consecutive severe seconds enter unavailable.
//- Unavailable threshold programmable 0 to 900.
//- Zero unavailable threshold never alarms.
//- Unavailable threshold resets to 10.
//- Unavailable count reaching threshold raises alarm.
//- Yellow reporting enabled at reset, set/clear.
package esam_pkg;

	// Clock rate and the one-second tick derived from it.
	localparam int unsigned CLK_HZ           = 125_000_000;
	localparam int unsigned TICK_SECONDS     = 1;
	localparam int unsigned TICK_CYCLES_DFLT = CLK_HZ * TICK_SECONDS;
	localparam int unsigned TICK_W           = 27;

	// Sliding window and threshold layout.
	localparam int unsigned WIN_MINUTES = 15;
	localparam int unsigned WIN_SECS    = 60 * WIN_MINUTES;
	localparam int unsigned CNT_W       = 10;
	localparam logic [CNT_W-1:0] THR_MAX     = 10'h384;
	localparam logic [CNT_W-1:0] ES_THR_RST  = 10'h041;
	localparam logic [CNT_W-1:0] UAS_THR_RST = 10'h00A;
	localparam logic [CNT_W-1:0] PTR_LAST    = 10'h383;

	// Per-second event accounting.
	localparam int unsigned EVT_W   = 6;
	localparam logic [EVT_W-1:0] EVT_MAX  = 6'h3F;
	localparam logic [EVT_W-1:0] SES_EVTS = 6'h2C;

	// Unavailable-state entry and exit run lengths.
	localparam int unsigned RUN_W = 4;
	localparam logic [RUN_W-1:0] UAS_RUN = 4'hA;

	// Line events from the receiver and framer; levels, except the one-cycle code-violation pulse.
	typedef struct packed {
		logic los;   // Loss-of-signal level.
		logic oof;   // Out-of-frame level.
		logic cv;    // Code-violation pulse.
		logic ais;   // Incoming AIS detected, level.
		logic yel;   // Incoming yellow detected, level.
	} esam_line_s;

	// Management commands, each a one-cycle strobe.
	typedef struct packed {
		logic                  ais_alarm_on_cmd;
		logic                  ais_alarm_off_cmd;
		logic                  yellow_alarm_on_cmd;
		logic                  yellow_alarm_off_cmd;
		logic                  errsec_threshold_cmd;
		logic                  unavail_threshold_cmd;
		logic [CNT_W-1:0]      value;
	} esam_cmd_s;

endpackage

// ===== verification/esam_line_model.sv
// Line receiver and framer model that plays one programmed second of line events.
module esam_line_model
	import esam_pkg::*;
(
	// Clock and the second boundary.
	input  wire logic       i_clk,
	input  wire logic       i_tick,
	// Program for the next second and the alarm levels.
	input  wire logic       i_los,
	input  wire logic       i_oof,
	input  wire logic [5:0] i_cv_n,
	input  wire logic       i_ais,
	input  wire logic       i_yel,
	// Line events towards the monitor.
	output esam_line_s      o_line
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] cyc   = 8'hFF; // Cycles since the boundary; parks at the top.
	logic       los_f = 1'b0;  // Loss-of-signal entry wanted this second.
	logic       oof_f = 1'b0;  // Out-of-frame entry wanted this second.
	logic [5:0] cv_n  = 6'h00; // Violation pulses wanted this second.

	// The program is latched at the boundary so a whole second plays unchanged.
	always @(posedge i_clk) begin
		if (i_tick === 1'b1) begin
			cyc   <= 8'h00;
			los_f <= i_los;
			oof_f <= i_oof;
			cv_n  <= i_cv_n;
		end else if (cyc != 8'hFF) begin
			cyc <= cyc + 8'h01;
		end
	end

	// Levels rise once and fall well before the boundary, so each yields one entry.
	assign o_line = {los_f && cyc >= 8'h02 && cyc < 8'h14, oof_f && cyc >= 8'h03 && cyc < 8'h14,
		cyc < {2'h0, cv_n}, i_ais, i_yel};
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the errored-second alarm monitor.
`define CHK(nm, got, exp) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("mismatch %s expected %0h seen %0h", nm, exp, got); \
	end \
end
module tb_top
	import esam_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int unsigned TICKS = 64; // Long enough for 44 events in one second.
	typedef struct packed {
		logic [CNT_W-1:0] es;
		logic [CNT_W-1:0] us;
		logic             un;
		logic             al;
	} esam_exp_s;

	logic             i_clk   = 1'b0;
	logic             i_rst_b = 1'b0;
	esam_cmd_s        i_cmd   = '0;
	esam_line_s       line_ev;
	logic             p_los = 1'b0, p_oof = 1'b0, ais = 1'b1, yel = 1'b1;
	logic [5:0]       p_cv  = 6'h00;
	logic             o_ais_alarm_enable, o_yellow_alarm_enable, o_ais_alarm, o_yellow_alarm;
	logic             o_excess_error_alarm, o_unavailable, o_second_tick;
	logic [CNT_W-1:0] o_errsec_count, o_unavail_count, o_errsec_threshold, o_unavail_threshold;
	wire  [3:0]       flags = {o_ais_alarm_enable, o_yellow_alarm_enable, o_ais_alarm, o_yellow_alarm};
	// Reference state of the monitor, kept apart from the design.
	int               run, clr, es, us, n_mismatch, check_count;
	bit               unav, have, aen, yen;
	bit               hes[$], hus[$];
	logic [CNT_W-1:0] ethr, uthr;
	esam_exp_s        pe, q[$];
	int               ord[4] = '{1, 0, 3, 2};
	logic [CNT_W-1:0] v[4];

	esam_line_model partner (.i_clk, .i_tick(o_second_tick), .i_los(p_los), .i_oof(p_oof),
		.i_cv_n(p_cv), .i_ais(ais), .i_yel(yel), .o_line(line_ev));
	esam_monitor #(.P_TICK_CYCLES(TICKS)) dut (.i_clk, .i_rst_b, .i_line(line_ev), .i_cmd,
		.o_ais_alarm_enable, .o_yellow_alarm_enable, .o_ais_alarm, .o_yellow_alarm,
		.o_excess_error_alarm, .o_unavailable, .o_errsec_count, .o_unavail_count,
		.o_errsec_threshold, .o_unavail_threshold, .o_second_tick);

	initial forever #4 i_clk = ~i_clk;

	// One second of the reference: severity runs, unavailable state and the window.
	function automatic void step(int ev);
		bit u;
		if (!unav) begin
			run = ev >= 44 ? run + 1 : 0;
			unav = run == 10;
			clr = 0;
		end else begin
			clr = ev >= 44 ? 0 : clr + 1;
			// The tenth quiet second closes the state and is available again.
			if (clr == 10) unav = 0;
		end
		u = unav;
		if (u) run = 0;
		hes.push_back(!u && ev > 0);
		hus.push_back(u);
		es += !u && ev > 0;
		us += u;
		// Seconds older than the window leave it again.
		if (hes.size() > 900) begin
			es -= hes.pop_front();
			us -= hus.pop_front();
		end
		pe = '{10'(es), 10'(us), unav, 1'b0};
	endfunction

	// Reset for eight cycles; the first, empty second also enters the window.
	task automatic rst();
		// Let the note of the last closed second be compared before counts clear.
		if (have) repeat (3) @(posedge i_clk);
		i_rst_b <= 1'b0;
		repeat (8) @(posedge i_clk);
		i_rst_b <= 1'b1;
		{run, clr, es, us, unav, aen, yen} = {32'h0, 32'h0, 32'h0, 32'h0, 3'h3};
		hes.delete();
		hus.delete();
		ethr = 10'h041;
		uthr = 10'h00A;
		step(0);
		have = 1'b1;
	endtask

	// One-cycle command strobe; the strobes sit in the top six bits, AIS-on first.
	task automatic cmd(int k, logic [CNT_W-1:0] val);
		i_cmd <= esam_cmd_s'({6'h20 >> k, val});
		@(posedge i_clk);
		i_cmd <= '0;
		if (k < 2) aen = k == 0;
		else if (k < 4) yen = k == 2;
		else if (val <= 10'h384 && k == 4) ethr = val;
		else if (val <= 10'h384) uthr = val;
		repeat (2) @(posedge i_clk);
	endtask

	// Program the next second; the note for the second that just closed is queued.
	task automatic sec(bit l, bit o, int n);
		p_los <= l;
		p_oof <= o;
		p_cv  <= 6'(n);
		do @(posedge i_clk); while (o_second_tick !== 1'b1);
		// The alarm is judged with the thresholds in force when the second closes.
		if (have) q.push_back(esam_exp_s'{pe.es, pe.us, pe.un,
			(ethr != 0 && pe.es >= ethr) || (uthr != 0 && pe.us >= uthr)});
		step(l + o + n);
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Counts settle one cycle and the alarm two cycles after each boundary.
	initial begin
		esam_exp_s e;
		forever begin
			@(posedge i_clk iff o_second_tick === 1'b1);
			repeat (2) @(posedge i_clk);
			if (q.size() > 0) begin
				e = q.pop_front();
				`CHK("errsec_count", o_errsec_count, e.es)
				`CHK("unavail_count", o_unavail_count, e.us)
				`CHK("unavailable", o_unavailable, e.un)
				`CHK("excess_alarm", o_excess_error_alarm, e.al)
			end
		end
	end

	// Cuts a hang short; the full run needs about 60400 cycles.
	initial begin
		repeat (80000) @(posedge i_clk);
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		void'($urandom(32'h2659FE08));
		rst();
		repeat (2) @(posedge i_clk);
		`CHK("flags", flags, 4'hF)
		`CHK("thresholds", {o_errsec_threshold, o_unavail_threshold}, {10'h041, 10'h00A})
		foreach (ord[i]) begin
			cmd(ord[i], 10'h000);
			`CHK("flags", flags, {aen, yen, aen, yen})
		end
		// A random legal value, one past the top, the top and zero.
		for (int k = 4; k < 6; k++) begin
			v = '{10'($urandom % 901), 10'h385, 10'h384, 10'h000};
			foreach (v[j]) begin
				cmd(k, v[j]);
				`CHK("thresholds", {o_errsec_threshold, o_unavail_threshold}, {ethr, uthr})
			end
		end
		// Each kind of event alone makes an errored second.
		rst();
		cmd(4, 10'h003);
		cmd(5, 10'h000);
		sec(0, 0, 0);
		sec(1, 0, 0);
		sec(0, 1, 0);
		sec(0, 0, 1);
		sec(1, 1, 2);
		cmd(4, 10'h000);
		sec(0, 0, 1);
		sec(0, 0, 0);
		// A run of severe seconds broken at 43 events, then eleven in a row.
		cmd(5, 10'h001);
		repeat (9) sec(0, 0, 44);
		sec(0, 0, 43);
		repeat (11) sec(0, 0, 44);
		cmd(5, 10'h000);
		repeat (11) sec(0, 0, 0);
		// A full window of errored seconds against the top threshold, then one slide.
		rst();
		cmd(4, 10'h384);
		cmd(5, 10'h000);
		repeat (901) sec(0, 0, 1 + $urandom % 43);
		repeat (2) sec(0, 0, 0);
		repeat (4) @(posedge i_clk);
		tally_and_finish();
	end
endmodule
